// >>> common/eirs_pkg.sv
// constants and carrier types for the external interrupt pin and reset cause block
// assumes a 32-bit avalon-mm slave with byte addressing and registers in byte lane 0
package eirs_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_PIN_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_LV_CTRL = 4'h8;

  // ------------------------------------------------------------------
  // pin control and status fields
  // ------------------------------------------------------------------
  localparam int PIN_PULL_DISABLE_BIT = 6;
  localparam int PIN_POLARITY_BIT = 5;
  localparam int PIN_FUNCTION_EN_BIT = 4;
  localparam int PIN_EVENT_FLAG_BIT = 3;
  localparam int PIN_EVENT_ACK_BIT = 2;
  localparam int PIN_INT_EN_BIT = 1;
  localparam int PIN_DETECT_MODE_BIT = 0;

  // ------------------------------------------------------------------
  // reset cause fields, bits 3 and 0 read zero
  // ------------------------------------------------------------------
  localparam int CAUSE_POWER_ON_BIT = 7;
  localparam int CAUSE_PIN_BIT = 6;
  localparam int CAUSE_WATCHDOG_BIT = 5;
  localparam int CAUSE_ILLEGAL_OP_BIT = 4;
  localparam int CAUSE_CLOCK_LOSS_BIT = 2;
  localparam int CAUSE_LOW_VOLTAGE_BIT = 1;
  localparam logic [7:0] CAUSE_POWER_ON_VALUE = 8'h82;

  // ------------------------------------------------------------------
  // low-voltage control fields
  // ------------------------------------------------------------------
  localparam int LV_DETECT_EN_BIT = 0;
  localparam int LV_INT_EN_BIT = 1;
  localparam int LV_RESET_EN_BIT = 2;
  localparam int LV_STOP_EN_BIT = 3;
  localparam int LV_FLAG_BIT = 4;
  localparam int LV_ACK_BIT = 5;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic pull_disable;
    logic polarity_select;
    logic function_enable;
    logic int_enable;
    logic detection_mode;
  } eirs_pin_cfg_t;

  typedef struct packed {
    logic detect_enable;
    logic int_enable;
    logic reset_enable;
    logic stop_enable;
  } eirs_lv_cfg_t;

  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog;
    logic illegal_op;
    logic clock_loss;
    logic low_voltage;
  } eirs_cause_t;

endpackage : eirs_pkg

// >>> design/eirs_top.sv
// external interrupt pin unit and reset cause register behind an avalon-mm slave
// assumes reset-cause inputs come from the reset controller on MCLK and stay valid
// through the first clock edge after RESET_N releases; IRQ_PIN and LV_TRIP are asynchronous
//
// Operation
// RULE_01: with pin enabled, pull device off when pull-disable is 1, on when 0.
// RULE_02: polarity 0 detects falling edge or low level, 1 rising or high.
// RULE_03: pin enabled with rising polarity turns the pullup into a pulldown.
// RULE_04: pin serves as interrupt input only while pin-enable is 1.
// RULE_05: event flag set by qualifying detection; software cannot set it.
// RULE_06: writing 1 to acknowledge clears flag; 0 does nothing; reads return 0.
// RULE_07: in edge-and-level mode acknowledge cannot clear while pin stays asserted.
// RULE_08: interrupt enable 1 requests interrupt whenever event flag is 1.
// RULE_09: mode 0 is edge only; mode 1 responds to edge and sustained level.
// RULE_10: reset cause register holds read-only flags; writes never change them.
// RULE_11: debug forced reset leaves every cause flag cleared.
// RULE_12: any write to reset cause address restarts watchdog, flags unchanged.
// RULE_13: power-on reset sets power-on and low-voltage flags, clears others.
// RULE_14: low-voltage reset keeps power-on flag, sets low-voltage, clears others.
// RULE_15: other resets set flags of sources active at that moment, clear rest.
// RULE_16: external reset pin low level sets pin flag, bit 6.
// RULE_17: watchdog timeout sets watchdog flag, bit 5; blocked by watchdog enable 0.
// RULE_18: illegal opcode flag for bad opcode, disabled stop or disabled background.
// RULE_19: loss of external clock sets clock-loss flag, bit 2.
// RULE_20: reset and stop enables with low-voltage trip cause reset, set flag.
// RULE_21: reserved bits 3 and 0 of reset cause register read zero.
// RULE_22: detect and interrupt enabled, reset off: trip sets flag, raises interrupt.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eirs_top (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic POR_N,
  input wire logic [eirs_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [eirs_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [eirs_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic IRQ_PIN,
  output logic IRQ_PULL_EN,
  output logic IRQ_PULL_DOWN,
  output logic IRQ_REQ,
  input wire logic LV_TRIP,
  input wire logic STOP_ACTIVE,
  output logic LV_RESET_REQ,
  output logic LV_INT_REQ,
  output logic WDOG_RESTART,
  input wire logic CAUSE_LOW_VOLTAGE,
  input wire logic CAUSE_DEBUG_FORCE,
  input wire logic CAUSE_PIN,
  input wire logic CAUSE_WATCHDOG,
  input wire logic WATCHDOG_ENABLE,
  input wire logic CAUSE_ILLEGAL_OPCODE,
  input wire logic CAUSE_STOP_EXEC,
  input wire logic STOP_MODE_ENABLE,
  input wire logic CAUSE_BACKGROUND_INSTRUCTION_EXEC,
  input wire logic BACKGROUND_MODE_ENABLE,
  input wire logic CAUSE_CLOCK_LOSS
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  eirs_pkg::eirs_pin_cfg_t pin_cfg_q;
  eirs_pkg::eirs_lv_cfg_t lv_cfg_q;
  eirs_pkg::eirs_cause_t cause_q;
  eirs_pkg::eirs_cause_t cause_d;
  logic pin_meta_q;
  logic pin_sync_q;
  logic trip_meta_q;
  logic trip_sync_q;
  logic asserted_prev_q;
  logic pin_asserted;
  logic pin_edge;
  logic pin_event;
  logic pin_flag_q;
  logic lv_flag_q;
  logic lv_int_event;
  logic lv_reset_event;
  logic wait_q;
  logic bus_req;
  logic bus_commit;
  logic wr_commit;
  logic [7:0] rd_byte;
  logic reset_window_q;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // write strobe for one register, lane 0 only since data sits in the low byte
  function automatic logic reg_wr(input logic commit, input logic [eirs_pkg::ADDR_W-1:0] addr,
                                  input logic [eirs_pkg::ADDR_W-1:0] ofs, input logic lane0);
    reg_wr = commit & (addr == ofs) & lane0;
  endfunction : reg_wr

  // pack the cause flags into their byte positions
  function automatic logic [7:0] cause_byte(input eirs_pkg::eirs_cause_t c);
    logic [7:0] b;
    b = 8'h00;
    b[eirs_pkg::CAUSE_POWER_ON_BIT] = c.power_on;
    b[eirs_pkg::CAUSE_PIN_BIT] = c.pin;
    b[eirs_pkg::CAUSE_WATCHDOG_BIT] = c.watchdog;
    b[eirs_pkg::CAUSE_ILLEGAL_OP_BIT] = c.illegal_op;
    b[eirs_pkg::CAUSE_CLOCK_LOSS_BIT] = c.clock_loss;
    b[eirs_pkg::CAUSE_LOW_VOLTAGE_BIT] = c.low_voltage;
    cause_byte = b;
  endfunction : cause_byte

  // ------------------------------------------------------------------
  // avalon-mm slave
  // ------------------------------------------------------------------
  // one wait cycle: read data is registered, then waitrequest drops for one cycle
  // limitation: every access costs two cycles, traded for a registered read path
  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_commit = bus_req & ~wait_q;
  assign wr_commit = AVS_WRITE & ~wait_q;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_q <= 1'b1;
    end else if (bus_commit) begin
      wait_q <= 1'b1;
    end else if (bus_req) begin
      wait_q <= 1'b0;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (AVS_ADDRESS)
      eirs_pkg::OFS_PIN_CTRL: begin
        rd_byte[eirs_pkg::PIN_PULL_DISABLE_BIT] = pin_cfg_q.pull_disable;
        rd_byte[eirs_pkg::PIN_POLARITY_BIT] = pin_cfg_q.polarity_select;
        rd_byte[eirs_pkg::PIN_FUNCTION_EN_BIT] = pin_cfg_q.function_enable;
        rd_byte[eirs_pkg::PIN_EVENT_FLAG_BIT] = pin_flag_q;
        rd_byte[eirs_pkg::PIN_INT_EN_BIT] = pin_cfg_q.int_enable;
        rd_byte[eirs_pkg::PIN_DETECT_MODE_BIT] = pin_cfg_q.detection_mode;
      end
      eirs_pkg::OFS_RESET_CAUSE: begin
        rd_byte = cause_byte(cause_q); // RULE_21
      end
      eirs_pkg::OFS_LV_CTRL: begin
        rd_byte[eirs_pkg::LV_DETECT_EN_BIT] = lv_cfg_q.detect_enable;
        rd_byte[eirs_pkg::LV_INT_EN_BIT] = lv_cfg_q.int_enable;
        rd_byte[eirs_pkg::LV_RESET_EN_BIT] = lv_cfg_q.reset_enable;
        rd_byte[eirs_pkg::LV_STOP_EN_BIT] = lv_cfg_q.stop_enable;
        rd_byte[eirs_pkg::LV_FLAG_BIT] = lv_flag_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // acknowledge bits are never stored, so they read back as zero
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ & wait_q) begin
      AVS_READDATA <= {{(eirs_pkg::DATA_W-8){1'b0}}, rd_byte}; // RULE_06
    end
  end

  assign AVS_WAITREQUEST = wait_q;

  // ------------------------------------------------------------------
  // pin control register
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_cfg_q <= '0;
    end else if (reg_wr(wr_commit, AVS_ADDRESS, eirs_pkg::OFS_PIN_CTRL, AVS_BYTEENABLE[0])) begin
      pin_cfg_q.pull_disable <= AVS_WRITEDATA[eirs_pkg::PIN_PULL_DISABLE_BIT];
      pin_cfg_q.polarity_select <= AVS_WRITEDATA[eirs_pkg::PIN_POLARITY_BIT];
      pin_cfg_q.function_enable <= AVS_WRITEDATA[eirs_pkg::PIN_FUNCTION_EN_BIT];
      pin_cfg_q.int_enable <= AVS_WRITEDATA[eirs_pkg::PIN_INT_EN_BIT];
      pin_cfg_q.detection_mode <= AVS_WRITEDATA[eirs_pkg::PIN_DETECT_MODE_BIT];
    end
  end

  // ------------------------------------------------------------------
  // pin synchroniser and detector
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= IRQ_PIN;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign pin_asserted = pin_cfg_q.polarity_select ? pin_sync_q : ~pin_sync_q; // RULE_02

  // starts as asserted so the cleared synchroniser cannot fake an edge after reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      asserted_prev_q <= 1'b1;
    end else begin
      asserted_prev_q <= pin_asserted;
    end
  end

  assign pin_edge = pin_asserted & ~asserted_prev_q;
  // level term keeps the flag pinned while the pin holds its active level
  assign pin_event = pin_cfg_q.function_enable & // RULE_04
                     (pin_edge | (pin_cfg_q.detection_mode & pin_asserted)); // RULE_09

  // set wins over acknowledge in the same cycle
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_flag_q <= 1'b0;
    end else if (pin_event) begin
      pin_flag_q <= 1'b1; // RULE_05 RULE_07
    end else if (reg_wr(wr_commit, AVS_ADDRESS, eirs_pkg::OFS_PIN_CTRL, AVS_BYTEENABLE[0]) &&
                 AVS_WRITEDATA[eirs_pkg::PIN_EVENT_ACK_BIT]) begin
      pin_flag_q <= 1'b0; // RULE_06
    end
  end

  // ------------------------------------------------------------------
  // pin outputs
  // ------------------------------------------------------------------
  // pull stays off while the pin function is disabled
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_PULL_EN <= 1'b0;
    end else begin
      IRQ_PULL_EN <= pin_cfg_q.function_enable & ~pin_cfg_q.pull_disable; // RULE_01
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_PULL_DOWN <= 1'b0;
    end else begin
      IRQ_PULL_DOWN <= pin_cfg_q.function_enable & pin_cfg_q.polarity_select; // RULE_03
    end
  end

  // one cycle behind the flag, so a polling read may see the flag first
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= pin_cfg_q.int_enable & pin_flag_q; // RULE_08
    end
  end

  // ------------------------------------------------------------------
  // low-voltage control
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trip_meta_q <= 1'b0;
      trip_sync_q <= 1'b0;
    end else begin
      trip_meta_q <= LV_TRIP;
      trip_sync_q <= trip_meta_q;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lv_cfg_q <= '0;
    end else if (reg_wr(wr_commit, AVS_ADDRESS, eirs_pkg::OFS_LV_CTRL, AVS_BYTEENABLE[0])) begin
      lv_cfg_q.detect_enable <= AVS_WRITEDATA[eirs_pkg::LV_DETECT_EN_BIT];
      lv_cfg_q.int_enable <= AVS_WRITEDATA[eirs_pkg::LV_INT_EN_BIT];
      lv_cfg_q.reset_enable <= AVS_WRITEDATA[eirs_pkg::LV_RESET_EN_BIT];
      lv_cfg_q.stop_enable <= AVS_WRITEDATA[eirs_pkg::LV_STOP_EN_BIT];
    end
  end

  // detector is off in stop unless the stop enable keeps it alive
  assign lv_reset_event = trip_sync_q & lv_cfg_q.detect_enable & lv_cfg_q.reset_enable &
                          (~STOP_ACTIVE | lv_cfg_q.stop_enable); // RULE_20
  assign lv_int_event = trip_sync_q & lv_cfg_q.detect_enable & ~lv_cfg_q.reset_enable &
                        (~STOP_ACTIVE | lv_cfg_q.stop_enable); // RULE_22

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lv_flag_q <= 1'b0;
    end else if (lv_int_event) begin
      lv_flag_q <= 1'b1; // RULE_22
    end else if (reg_wr(wr_commit, AVS_ADDRESS, eirs_pkg::OFS_LV_CTRL, AVS_BYTEENABLE[0]) &&
                 AVS_WRITEDATA[eirs_pkg::LV_ACK_BIT]) begin
      lv_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LV_RESET_REQ <= 1'b0;
    end else begin
      LV_RESET_REQ <= lv_reset_event; // RULE_20
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LV_INT_REQ <= 1'b0;
    end else begin
      LV_INT_REQ <= lv_flag_q & lv_cfg_q.int_enable; // RULE_22
    end
  end

  // ------------------------------------------------------------------
  // watchdog restart
  // ------------------------------------------------------------------
  // any write, any lanes, restarts the count; stored flags are untouched
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WDOG_RESTART <= 1'b0;
    end else begin
      WDOG_RESTART <= wr_commit & (AVS_ADDRESS == eirs_pkg::OFS_RESET_CAUSE); // RULE_12
    end
  end

  // ------------------------------------------------------------------
  // reset cause capture
  // ------------------------------------------------------------------
  // high while RESET_N is low and at the first edge after release; cause inputs are sampled on each of those edges
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reset_window_q <= 1'b1;
    end else begin
      reset_window_q <= 1'b0;
    end
  end

  always_comb begin
    cause_d = cause_q;
    if (CAUSE_DEBUG_FORCE) begin
      cause_d = '0; // RULE_11
    end else if (CAUSE_LOW_VOLTAGE) begin
      cause_d = '0; // RULE_14
      cause_d.power_on = cause_q.power_on;
      cause_d.low_voltage = 1'b1;
    end else begin
      cause_d = '0; // RULE_15
      cause_d.pin = CAUSE_PIN; // RULE_16
      cause_d.watchdog = CAUSE_WATCHDOG & WATCHDOG_ENABLE; // RULE_17
      cause_d.illegal_op = CAUSE_ILLEGAL_OPCODE | // RULE_18
                           (CAUSE_STOP_EXEC & ~STOP_MODE_ENABLE) |
                           (CAUSE_BACKGROUND_INSTRUCTION_EXEC & ~BACKGROUND_MODE_ENABLE);
      cause_d.clock_loss = CAUSE_CLOCK_LOSS; // RULE_19
    end
  end

  // power-on alone resets this store; warm resets reload it from cause_d, keeping the
  // power-on flag only on low-voltage resets; no bus path writes it
  always_ff @(posedge MCLK or negedge POR_N) begin
    if (!POR_N) begin
      cause_q <= '0;
      cause_q.power_on <= 1'b1; // RULE_13
      cause_q.low_voltage <= 1'b1; // RULE_13
    end else if (reset_window_q) begin
      cause_q <= cause_d; // RULE_10
    end
  end

endmodule : eirs_top

// >>> bench/eirs_pin_src.sv
// model of the external interrupt source on the pin
// assumes the bench moves the drive level just after a clock edge
`timescale 1ns/1ps
module eirs_pin_src (
  input wire logic clk,
  input wire logic drive_en,
  input wire logic drive_lvl,
  input wire logic pull_en,
  input wire logic pull_down,
  output logic pin
);
  // --------
  // pin level
  // --------
  logic last_q;
  always_ff @(posedge clk) begin
    if (drive_en) begin
      last_q <= drive_lvl;
    end
  end
  // released and unpulled: never show a stale copy of the last level
  assign pin = drive_en ? drive_lvl : pull_en ? !pull_down : !last_q;
endmodule : eirs_pin_src

// >>> bench/eirs_top_assertions.sv
// port checks for the pin unit and the reset-cause register
// assumes one clock, MCLK, and the active-low RESET_N
`timescale 1ns/1ps
module eirs_top_chk (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ_PIN,
  input wire logic IRQ_PULL_EN,
  input wire logic IRQ_PULL_DOWN,
  input wire logic IRQ_REQ,
  input wire logic WDOG_RESTART
);
  // --------
  // committed accesses, shadow of pin control
  // --------
  logic go, wr0, wr4, rd0, rd4, armed, seen_q;
  logic [7:0] cfg_q, cause_q;
  logic [2:0] age_q;
  assign go = !AVS_WAITREQUEST;
  assign wr0 = go && AVS_WRITE && AVS_BYTEENABLE[0] && AVS_ADDRESS == eirs_pkg::OFS_PIN_CTRL;
  assign wr4 = go && AVS_WRITE && AVS_ADDRESS == eirs_pkg::OFS_RESET_CAUSE;
  assign rd0 = go && AVS_READ && AVS_ADDRESS == eirs_pkg::OFS_PIN_CTRL;
  assign rd4 = go && AVS_READ && AVS_ADDRESS == eirs_pkg::OFS_RESET_CAUSE;
  assign armed = age_q == 3'h7 && cfg_q[4] && cfg_q[1];
  // ack writes keep the age so level checks run across them
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_q <= 8'h00;
      age_q <= 3'h7;
    end else if (wr0 && (AVS_WRITEDATA[7:0] & 8'h73) != cfg_q) begin
      cfg_q <= AVS_WRITEDATA[7:0] & 8'h73;
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seen_q <= 1'h0;
      cause_q <= 8'h00;
    end else if (rd4) begin
      seen_q <= 1'h1;
      cause_q <= AVS_READDATA[7:0];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence s_edge;
    armed && IRQ_PIN != cfg_q[5] ##1 armed && IRQ_PIN == cfg_q[5];
  endsequence
  sequence s_level;
    (armed && cfg_q[0] && IRQ_PIN == cfg_q[5]) [*6];
  endsequence
  a_wait_one_cycle:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("wait state longer than one cycle");
  a_pull_enable:
    assert property (age_q >= 3'h3 |-> IRQ_PULL_EN == (cfg_q[4] && !cfg_q[6]))
    else $error("pull enable does not follow pin control");
  a_pull_down_sel:
    assert property (age_q >= 3'h3 |-> IRQ_PULL_DOWN == (cfg_q[4] && cfg_q[5]))
    else $error("pull direction does not follow polarity");
  a_edge_raises_irq:
    assert property (s_edge |-> ##[2:6] IRQ_REQ)
    else $error("qualifying edge raised no request");
  a_level_holds_irq:
    assert property (s_level |-> IRQ_REQ)
    else $error("asserted level not holding the request");
  a_irq_needs_enable:
    assert property (IRQ_REQ && age_q >= 3'h2 |-> cfg_q[1])
    else $error("request while interrupt enable is clear");
  a_ack_reads_zero:
    assert property (rd0 |-> AVS_READDATA[2] == 1'h0 && AVS_READDATA[31:8] == 24'h0)
    else $error("acknowledge bit read back as one");
  a_cause_reserved_zero:
    assert property (rd4 |-> AVS_READDATA[3] == 1'h0 && AVS_READDATA[0] == 1'h0)
    else $error("reserved cause bit read as one");
  a_cause_read_only:
    assert property (rd4 && seen_q |-> AVS_READDATA[7:0] == cause_q)
    else $error("reset cause changed without a reset");
  a_restart_pulse:
    assert property (wr4 |=> WDOG_RESTART ##1 !WDOG_RESTART)
    else $error("no single restart pulse after cause write");
  a_restart_cause:
    assert property (WDOG_RESTART |-> $past(wr4))
    else $error("restart pulse without a cause write");
endmodule : eirs_top_chk

bind eirs_top eirs_top_chk u_chk (.MCLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ_PIN,
  .IRQ_PULL_EN, .IRQ_PULL_DOWN, .IRQ_REQ, .WDOG_RESTART);

// >>> bench/tb.sv
// self-checking bench for the pin unit and the reset-cause register
// assumes the pin source model and the bound checker are compiled first
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] pc = eirs_pkg::OFS_PIN_CTRL;
  localparam logic [3:0] rc = eirs_pkg::OFS_RESET_CAUSE;
  localparam logic [3:0] lc = eirs_pkg::OFS_LV_CTRL;
  logic MCLK, RESET_N, POR_N, AVS_READ, AVS_WRITE, IRQ_PIN, LV_TRIP, STOP_ACTIVE;
  logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic AVS_WAITREQUEST, IRQ_PULL_EN, IRQ_PULL_DOWN, IRQ_REQ, LV_RESET_REQ, LV_INT_REQ;
  logic WDOG_RESTART, drv_lvl;
  logic [10:0] cause;
  logic [7:0] v, cfg;
  int fails, total_checks;
  logic [18:0] tbl [13] = '{19'h20082, 19'h08040, 19'h28002, 19'h18000, 19'h06020,
    19'h04000, 19'h01010, 19'h00810, 19'h00c00, 19'h00210, 19'h00300, 19'h40004, 19'h4e064};

  eirs_top uut (.MCLK, .RESET_N, .POR_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ_PIN, .IRQ_PULL_EN, .IRQ_PULL_DOWN,
    .IRQ_REQ, .LV_TRIP, .STOP_ACTIVE, .LV_RESET_REQ, .LV_INT_REQ, .WDOG_RESTART,
    .CAUSE_CLOCK_LOSS(cause[10]), .CAUSE_LOW_VOLTAGE(cause[9]), .CAUSE_DEBUG_FORCE(cause[8]),
    .CAUSE_PIN(cause[7]), .CAUSE_WATCHDOG(cause[6]), .WATCHDOG_ENABLE(cause[5]),
    .CAUSE_ILLEGAL_OPCODE(cause[4]), .CAUSE_STOP_EXEC(cause[3]), .STOP_MODE_ENABLE(cause[2]),
    .CAUSE_BACKGROUND_INSTRUCTION_EXEC(cause[1]), .BACKGROUND_MODE_ENABLE(cause[0]));
  eirs_pin_src src (.clk(MCLK), .drive_en(1'h1), .drive_lvl(drv_lvl), .pull_en(IRQ_PULL_EN),
    .pull_down(IRQ_PULL_DOWN), .pin(IRQ_PIN));

  // --------
  // bus and check tasks
  // --------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask : cyc

  // the request stands until waitrequest is seen low, or for at most 20 cycles
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] e);
    int n;
    n = 0;
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= e;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'h0 && n < 20);
    v = AVS_READDATA[7:0];
    AVS_WRITE <= 1'h0;
    AVS_READ <= 1'h0;
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'h0, a, 8'h00, 4'h1);
    check(v, exp);
  endtask : rd

  task automatic do_reset(input logic [10:0] c);
    @(posedge MCLK);
    RESET_N <= 1'h0;
    cause <= c;
    cyc(3);
    RESET_N <= 1'h1;
    cyc(2);
    cause <= 11'h000;
  endtask : do_reset

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    MCLK = 1'h0;
    forever #2.5 MCLK = ~MCLK;
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    test_done();
  end

  initial begin
    {RESET_N, POR_N, AVS_READ, AVS_WRITE, LV_TRIP, STOP_ACTIVE} = 6'h00;
    {AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA} = 40'h0;
    drv_lvl = 1'h1;
    cause = 11'h200;
    fails = 0;
    total_checks = 0;
    cyc(5);
    POR_N <= 1'h1;
    RESET_N <= 1'h1;
    cyc(2);
    cause <= 11'h000;
    rd(rc, 8'h82);
    rd(pc, 8'h00);
    rd(lc, 8'h00);
    rd(4'hc, 8'h00);
    bus(1'h1, rc, 8'hff, 4'h1);
    bus(1'h1, rc, 8'h00, 4'h0);
    rd(rc, 8'h82);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      cfg = {1'h0, i[2:0], 4'h0};
      bus(1'h1, pc, cfg | 8'h04, 4'h1);
      cyc(3);
      check({6'h0, IRQ_PULL_EN, IRQ_PULL_DOWN}, {6'h0, i[0] & !i[2], i[0] & i[1]});
      bus(1'h0, pc, 8'h00, 4'h1);
      check(v & 8'h74, cfg);
    end
    for (int p = 0; p < 2; p++) begin
      cfg = p[0] ? 8'h32 : 8'h12;
      drv_lvl <= !p[0];
      bus(1'h1, pc, cfg | 8'h0c, 4'h1);
      cyc(4);
      bus(1'h1, pc, cfg | 8'h04, 4'h1);
      rd(pc, cfg);
      drv_lvl <= p[0];
      cyc(6);
      check({7'h0, IRQ_REQ}, 8'h01);
      bus(1'h1, pc, cfg, 4'h1);
      rd(pc, cfg | 8'h08);
      bus(1'h1, pc, cfg | 8'h04, 4'h1);
      cyc(3);
      check({7'h0, IRQ_REQ}, 8'h00);
      rd(pc, cfg);
    end
    cfg = 8'h13;
    drv_lvl <= 1'h1;
    bus(1'h1, pc, cfg | 8'h04, 4'h1);
    cyc(4);
    bus(1'h1, pc, cfg | 8'h04, 4'h1);
    drv_lvl <= 1'h0;
    cyc(6);
    bus(1'h1, pc, cfg | 8'h04, 4'h1);
    cyc(2);
    check({7'h0, IRQ_REQ}, 8'h01);
    rd(pc, cfg | 8'h08);
    drv_lvl <= 1'h1;
    cyc(4);
    bus(1'h1, pc, cfg | 8'h04, 4'h1);
    rd(pc, cfg);
    cfg = 8'h02;
    bus(1'h1, pc, cfg | 8'h04, 4'h1);
    drv_lvl <= 1'h0;
    cyc(6);
    drv_lvl <= 1'h1;
    cyc(6);
    check({7'h0, IRQ_REQ}, 8'h00);
    rd(pc, cfg);
    bus(1'h1, pc, 8'h10, 4'h1);
    drv_lvl <= 1'h0;
    cyc(6);
    check({7'h0, IRQ_REQ}, 8'h00);
    rd(pc, 8'h18);
    $display("test pin done");
    bus(1'h1, lc, 8'h03, 4'h1);
    LV_TRIP <= 1'h1;
    cyc(6);
    check({6'h0, LV_INT_REQ, LV_RESET_REQ}, 8'h02);
    rd(lc, 8'h13);
    STOP_ACTIVE <= 1'h1;
    bus(1'h1, lc, 8'h0d, 4'h1);
    cyc(4);
    check({6'h0, LV_INT_REQ, LV_RESET_REQ}, 8'h01);
    LV_TRIP <= 1'h0;
    STOP_ACTIVE <= 1'h0;
    $display("test low voltage done");
    for (int k = 0; k < 13; k++) begin
      do_reset(tbl[k][18:8]);
      rd(rc, tbl[k][7:0]);
    end
    $display("test causes done");
    test_done();
  end
endmodule : tb
